// File: core/sram_access_pkg.sv
package sram_access_pkg;
  localparam int unsigned WORD_COUNT = 2048;
  localparam int unsigned INDEX_WIDTH = 11;
  localparam int unsigned BYTE_WIDTH = 8;
  localparam int unsigned CLOCK_PERIOD_NS = 50;
  localparam int unsigned READ_LATENCY_MAX_NS = 200;
  localparam int unsigned WRITE_PULSE_MIN_NS = 150;
  localparam int unsigned WRITE_DATA_LEAD_NS = 90;
  localparam int unsigned WRITE_DATA_TRAIL_NS = 0;
  localparam int unsigned READ_CYCLES =
    (READ_LATENCY_MAX_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int unsigned WRITE_PULSE_CYCLES =
    (WRITE_PULSE_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int unsigned WRITE_LEAD_CYCLES =
    (WRITE_DATA_LEAD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int unsigned WRITE_TRAIL_CYCLES =
    ((WRITE_DATA_TRAIL_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS) > 0 ?
    ((WRITE_DATA_TRAIL_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS) : 1;
  localparam int unsigned COUNT_WIDTH = 4;
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [10:0] INDEX_RESET = 11'h000;
endpackage

// File: core/sync_pair.sv
module sync_pair #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] synced_out
);
  logic [WIDTH-1:0] stage_one;
  logic [WIDTH-1:0] next_stage_one;
  logic [WIDTH-1:0] next_synced;

  always_comb
  begin
    next_stage_one = async_in;
    next_synced = stage_one;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      stage_one <= '0;
      synced_out <= '0;
    end
    else
    begin
      stage_one <= next_stage_one;
      synced_out <= next_synced;
    end
  end
endmodule

// File: core/sram_host.sv
// What this block does
// - A read holds both selects low and write-select high while the memory drives the byte.
// - The write overlap of the three controls lasts at least 150 ns.
// - Write data stands 90 ns before the write ends and 0 ns after it.
// - Write-select may stay low while both selects, moving together, time the write.
module sram_host (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [10:0] req_index_in,
  input wire logic [7:0] req_byte_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [7:0] rsp_byte_out,
  output logic [10:0] word_index_out,
  output logic select_a_n_out,
  output logic select_b_n_out,
  output logic write_select_n_out,
  input wire logic [7:0] byte_lines_in,
  output logic [7:0] byte_lines_out,
  output logic byte_lines_oe_n_out
);
  typedef enum logic [2:0] {
    IDLE,
    READ_WAIT,
    READ_SAMPLE,
    WRITE_SETUP,
    WRITE_ACTIVE,
    WRITE_HOLD,
    RECOVER
  } state_t;

  state_t state;
  state_t next_state;
  logic [sram_access_pkg::COUNT_WIDTH-1:0] count;
  logic [sram_access_pkg::COUNT_WIDTH-1:0] next_count;

  logic [10:0] index;
  logic [10:0] next_index;
  logic [7:0] wbyte;
  logic [7:0] next_wbyte;
  logic [7:0] rbyte;
  logic [7:0] next_rbyte;
  logic rvalid;
  logic next_rvalid;

  logic sel_n;
  logic next_sel_n;
  logic we_n;
  logic next_we_n;
  logic oe_n;
  logic next_oe_n;

  logic [7:0] lines_synced;

  localparam logic [3:0] READ_LAST = 4'(sram_access_pkg::READ_CYCLES - 1);
  // Data settles only at the end of the latency window and then crosses both sync stages;
  // sampling a cycle sooner would race the memory's access time
  localparam logic [3:0] SAMPLE_LAST = 4'(sram_access_pkg::SYNC_STAGES);
  localparam logic [3:0] PULSE_LAST = 4'(sram_access_pkg::WRITE_PULSE_CYCLES - 1);
  localparam logic [3:0] TRAIL_LAST = 4'(sram_access_pkg::WRITE_TRAIL_CYCLES - 1);

  sync_pair #(
    .WIDTH(sram_access_pkg::BYTE_WIDTH)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(byte_lines_in),
    .synced_out(lines_synced)
  );

  always_comb
  begin
    next_state = state;
    next_count = count;
    next_index = index;
    next_wbyte = wbyte;
    next_rbyte = rbyte;
    next_rvalid = 1'b0;
    next_sel_n = sel_n;
    next_we_n = we_n;
    next_oe_n = oe_n;
    case (state)
      IDLE:
      begin
        next_sel_n = 1'b1;
        next_we_n = 1'b1;
        next_oe_n = 1'b1;
        if (req_valid_in)
        begin
          next_index = req_index_in;
          next_count = '0;
          if (req_write_in)
          begin
            // Write-select and our driver go first; selects follow a cycle later
            next_wbyte = req_byte_in;
            next_we_n = 1'b0;
            next_oe_n = 1'b0;
            next_state = WRITE_SETUP;
          end
          else
          begin
            next_sel_n = 1'b0;
            next_state = READ_WAIT;
          end
        end
      end
      READ_WAIT:
      begin
        next_count = count + 4'h1;
        if (count == READ_LAST)
        begin
          next_count = '0;
          next_state = READ_SAMPLE;
        end
      end
      READ_SAMPLE:
      begin
        next_count = count + 4'h1;
        if (count == SAMPLE_LAST)
        begin
          next_rbyte = lines_synced;
          next_rvalid = 1'b1;
          next_sel_n = 1'b1;
          next_count = '0;
          next_state = RECOVER;
        end
      end
      WRITE_SETUP:
      begin
        next_sel_n = 1'b0;
        next_count = '0;
        next_state = WRITE_ACTIVE;
      end
      WRITE_ACTIVE:
      begin
        next_count = count + 4'h1;
        // Pulse covers both the overlap and the data lead, which is shorter
        if (count == PULSE_LAST)
        begin
          next_sel_n = 1'b1;
          next_count = '0;
          next_state = WRITE_HOLD;
        end
      end
      WRITE_HOLD:
      begin
        // Write-select rises after the selects, so the memory never turns its drivers on
        next_count = count + 4'h1;
        if (count == TRAIL_LAST)
        begin
          next_we_n = 1'b1;
          next_oe_n = 1'b1;
          next_count = '0;
          next_state = RECOVER;
        end
      end
      RECOVER:
      begin
        // One released cycle lets the memory's drivers turn off before the next access
        next_state = IDLE;
      end
      default:
      begin
        // An unknown state releases the pins at the next clock edge
        next_sel_n = 1'b1;
        next_we_n = 1'b1;
        next_oe_n = 1'b1;
        next_state = IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      // Pins come up released, so the memory stays deselected through reset
      state <= IDLE;
      count <= '0;
      index <= sram_access_pkg::INDEX_RESET;
      wbyte <= sram_access_pkg::BYTE_RESET;
      rbyte <= sram_access_pkg::BYTE_RESET;
      rvalid <= 1'b0;
      sel_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      index <= next_index;
      wbyte <= next_wbyte;
      rbyte <= next_rbyte;
      rvalid <= next_rvalid;
      sel_n <= next_sel_n;
      we_n <= next_we_n;
      oe_n <= next_oe_n;
    end
  end

  assign req_ready_out = (state == IDLE);
  assign rsp_valid_out = rvalid;
  assign rsp_byte_out = rbyte;
  assign word_index_out = index;
  // Both selects move together; a single device gains nothing from split timing
  assign select_a_n_out = sel_n;
  assign select_b_n_out = sel_n;
  assign write_select_n_out = we_n;
  assign byte_lines_out = wbyte;
  assign byte_lines_oe_n_out = oe_n;
endmodule

// File: sim/sram_host_sva.sv
module sram_host_sva (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [10:0] word_index_out,
  input wire logic select_a_n_out,
  input wire logic select_b_n_out,
  input wire logic write_select_n_out,
  input wire logic [7:0] byte_lines_out,
  input wire logic byte_lines_oe_n_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence write_open;
    !write_select_n_out && $fell(select_a_n_out);
  endsequence
  sequence read_open;
    write_select_n_out && $fell(select_a_n_out);
  endsequence
  a_read_float: assert property (!select_a_n_out && write_select_n_out |-> byte_lines_oe_n_out)
    else $error("host drives bus in read");
  a_write_pulse: assert property (write_open |-> (!select_a_n_out && !select_b_n_out)[*3])
    else $error("write too short");
  a_select_timed: assert property (write_open |-> !$past(write_select_n_out) && !select_b_n_out)
    else $error("write not select timed");
  a_write_end: assert property ($rose(select_a_n_out) && !$past(write_select_n_out) |->
    !write_select_n_out) else $error("write select rose first");
  a_data_hold: assert property (!write_select_n_out && !$fell(write_select_n_out) |->
    $stable(byte_lines_out) && !byte_lines_oe_n_out) else $error("write data moved");
  a_index_hold: assert property (!select_a_n_out && !$fell(select_a_n_out) |->
    $stable(word_index_out)) else $error("index moved");
  a_read_span: assert property (read_open |-> (!select_a_n_out && write_select_n_out)[*7])
    else $error("read select too short");
endmodule

bind sram_host sram_host_sva chk_u (.ref_clk_in, .rst_n_in, .word_index_out, .select_a_n_out,
  .select_b_n_out, .write_select_n_out, .byte_lines_out, .byte_lines_oe_n_out);

// File: sim/sram_model.sv
module sram_model (
  input wire logic [10:0] idx_in,
  input wire logic sa_n_in,
  input wire logic sb_n_in,
  input wire logic we_n_in,
  input wire logic [7:0] bus_in,
  output logic [7:0] bus_out,
  output logic drv_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] store [0:2047];
  wire logic sel = !sa_n_in && !sb_n_in;
  initial bus_out = 8'h5A;
  assign drv_out = sel && we_n_in;
  always @(sel, we_n_in, idx_in, bus_in)
  begin
    if (sel && !we_n_in)
      store[idx_in] = bus_in;
  end
  // Garbage until the access time runs out, so an early sample fails
  always @(sel, we_n_in, idx_in)
  begin
    bus_out = ~store[idx_in];
    bus_out <= #200 store[idx_in];
  end
endmodule

// File: sim/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic req_valid_in = 1'b0;
  logic req_write_in = 1'b0;
  logic [10:0] req_index_in = 11'h000;
  logic [7:0] req_byte_in = 8'h00;
  logic req_ready_out, rsp_valid_out, select_a_n_out, select_b_n_out;
  logic write_select_n_out, byte_lines_oe_n_out, drv;
  logic [7:0] rsp_byte_out, byte_lines_out, mem_byte;
  logic [10:0] word_index_out;
  wire logic [7:0] byte_lines_in = !byte_lines_oe_n_out ? byte_lines_out :
    drv ? mem_byte : ~mem_byte;
  int n_errors = 0;
  int n_compared = 0;
  localparam int unsigned READ_SPAN =
    sram_access_pkg::READ_CYCLES + sram_access_pkg::SYNC_STAGES + 1;
  localparam int unsigned WRITE_SPAN =
    sram_access_pkg::WRITE_PULSE_CYCLES + sram_access_pkg::WRITE_TRAIL_CYCLES + 2;
  sram_host dut_u (.*);
  sram_model mem_u (.idx_in(word_index_out), .sa_n_in(select_a_n_out),
    .sb_n_in(select_b_n_out), .we_n_in(write_select_n_out), .bus_in(byte_lines_in),
    .bus_out(mem_byte), .drv_out(drv));
  initial
  begin
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic req(input logic w, input logic [10:0] i, input logic [7:0] b);
    @(negedge ref_clk_in);
    req_valid_in = 1'b1;
    req_write_in = w;
    req_index_in = i;
    req_byte_in = b;
    repeat (20) if (req_ready_out !== 1'b1) @(negedge ref_clk_in);
    @(negedge ref_clk_in);
    req_valid_in = 1'b0;
  endtask
  task automatic rd(input logic [10:0] i, input logic [7:0] e);
    int k;
    req(1'b0, i, 8'h00);
    for (k = 0; k < 12 && rsp_valid_out !== 1'b1; k++) @(negedge ref_clk_in);
    chk(8'(k), 8'(READ_SPAN));
    chk(rsp_byte_out, e);
  endtask
  task automatic wr(input logic [10:0] i, input logic [7:0] b);
    int k;
    req(1'b1, i, b);
    for (k = 0; k < 12 && req_ready_out !== 1'b1; k++) @(negedge ref_clk_in);
    chk(8'(k), 8'(WRITE_SPAN));
  endtask
  task automatic t_edges;
    wr(11'h000, 8'hA5);
    wr(11'h7FF, 8'h3C);
    rd(11'h000, 8'hA5);
    rd(11'h7FF, 8'h3C);
  endtask
  task automatic t_overwrite;
    wr(11'h2AA, 8'h11);
    wr(11'h2AA, 8'hEE);
    rd(11'h2AA, 8'hEE);
    rd(11'h2AA, 8'hEE);
  endtask
  task automatic t_reset;
    req(1'b1, 11'h123, 8'h77);
    @(negedge ref_clk_in);
    rst_n_in = 1'b0;
    #1 chk({select_a_n_out, select_b_n_out, write_select_n_out, byte_lines_oe_n_out, 4'h0},
      8'hF0);
    @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    rd(11'h7FF, 8'h3C);
  endtask
  task automatic end_sim;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    t_edges;
    t_overwrite;
    t_reset;
    end_sim;
  end
  initial
  begin
    #100000;
    n_errors++;
    end_sim;
  end
endmodule
